// File: src/lps_event_select.sv
/*
 * lps_event_select: per-cycle event selection for the link unit performance
 * monitor, with an AHB-Lite register slave for the event code and mask.
 * Assumes event inputs come from logic on hclk, and that the attached
 * counter adds the increment output on every hclk edge.
 */
// What this block does
// R1: code 0x53 counts each cycle the home data response bypass is used.
// R2: 0x77 counts credit idle flits in, 0x6B credit returns out, one per cycle.
// R3: code 0x54 counts home coherence request bypass use, one per cycle.
// R4: egress mask bits 13:8 select ring and direction; zero mask counts nothing.
// R5: several enabled subevents add the number occurring in that cycle.
// R6: even and odd egress FIFOs of one direction never win together.
// R7: bypass per direction is the even plus the odd FIFO bypass.
// R8: 0x40 counts egress bypass, 0x43 starvation cycles, both mask qualified.
// R9: 0x41 counts arbitration wins, 0x42 losses, both mask qualified.
// R10: flits out per class at 0x65, 0x67, 0x69; the last up to 11.
// R11: code 0x30 counts half line early sends toward the ring.
// R12: 0x87 counts request ring sends blocked by missing egress credit.
// R13: 0x88 counts acknowledge ring sends blocked by missing egress credit.
// R14: 0x89 counts data ring sends blocked by missing egress credit.
// R15: 0x80 to 0x85 count per class sends lacking class and pool credit.
// R16: 0x8A counts snoops blocked by a missing probe queue credit.
// R17: 0x86 counts pool exhaustion per selected side, adding both sides.
// R18: 0x73 counts data packets from home; flits are nine per packet.
// R19: 0x72 counts data packets from router, up to 9 per cycle.
// R20: increment presented each cycle, zero for an undefined code.
`timescale 1ns/1ns
`default_nettype none

module lps_event_select
    import lps_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // event sources
    input wire lps_events_t events,
    // counter side
    output logic [LPS_INC_W-1:0] inc_out
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // number of set bits in a six-bit vector selected by the mask
    function automatic logic [LPS_INC_W-1:0] count_sel(
        input logic [LPS_DIRS-1:0] mask,
        input logic [LPS_DIRS-1:0] ev
    );
        logic [LPS_INC_W-1:0] acc;
        acc = '0;
        for (int i = 0; i < LPS_DIRS; i++) begin
            acc = acc + {3'h0, mask[i] & ev[i]}; // R5
        end
        return acc;
    endfunction

    // even plus odd per direction, summed over the selected directions
    function automatic logic [LPS_INC_W-1:0] count_pair(
        input logic [LPS_DIRS-1:0] mask,
        input logic [LPS_DIRS-1:0] even,
        input logic [LPS_DIRS-1:0] odd
    );
        return LPS_INC_W'(count_sel(mask, even) + count_sel(mask, odd));
    endfunction

    // widen a single event bit to an increment
    function automatic logic [LPS_INC_W-1:0] one(input logic b);
        return {3'h0, b};
    endfunction

    // ------------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------------
    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] addr_r;
    logic access_ok;

    // a transfer is taken only on a valid address phase while the bus is ready
    assign access_ok = hsel && hready && (htrans == LPS_HTRANS_NONSEQ || htrans == LPS_HTRANS_SEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= access_ok && hwrite;
            rd_pend_r <= access_ok && !hwrite;
            if (access_ok) begin
                addr_r <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
            end
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    lps_select_t sel_r;
    lps_select_t sel_nxt;
    logic seen_clear;

    // writes land in the data phase, when hwdata is valid
    always_comb begin
        sel_nxt = sel_r;
        seen_clear = 1'b0;
        if (wr_pend_r && addr_r == LPS_ADDR_CTRL) begin
            sel_nxt.code = hwdata[LPS_CTRL_CODE_LSB +: 8];
            sel_nxt.mask = hwdata[LPS_CTRL_MASK_LSB +: 8];
            sel_nxt.enable = hwdata[LPS_CTRL_EN_BIT];
        end
        if (wr_pend_r && addr_r == LPS_ADDR_STATUS) begin
            seen_clear = hwdata[LPS_STAT_SEEN_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_r <= lps_select_t'(LPS_CTRL_RESET[16:0]);
        end else begin
            sel_r <= sel_nxt;
        end
    end

    // ------------------------------------------------------------------
    // event selection
    // ------------------------------------------------------------------
    logic [LPS_INC_W-1:0] inc_nxt;
    logic known_nxt;
    logic [LPS_DIRS-1:0] dir_mask;

    assign dir_mask = sel_r.mask[LPS_DIRS-1:0]; // R4

    // combinational pick of the programmed event; undefined codes give zero
    always_comb begin
        inc_nxt = '0;
        known_nxt = 1'b1;
        unique case (sel_r.code)
            LPS_EV_HOME_TO_LINK_DATA_BYPASS: begin
                inc_nxt = one(events.home_data_bypass); // R1
            end
            LPS_EV_HOME_CREDIT_CARRIER_FLITS: begin
                inc_nxt = one(events.home_credit_carrier); // R2
            end
            LPS_EV_HOME_CREDIT_RETURN_FLITS: begin
                inc_nxt = one(events.home_credit_return); // R2
            end
            LPS_EV_HOME_REQUEST_BYPASS: begin
                inc_nxt = one(events.home_request_bypass); // R3
            end
            LPS_EV_EGRESS_BYPASS: begin
                // each direction adds its even and odd bypass
                inc_nxt = count_pair(dir_mask, events.bypass_even, events.bypass_odd); // R7
            end
            LPS_EV_EGRESS_ARBITRATION_WINS: begin
                // even and odd wins are exclusive, so each direction adds 0 or 1
                inc_nxt = count_pair(dir_mask, events.win_even, events.win_odd); // R6
            end
            LPS_EV_EGRESS_ARBITRATION_LOSSES: begin
                inc_nxt = count_sel(dir_mask, events.loss); // R9
            end
            LPS_EV_EGRESS_STARVATION_CYCLES: begin
                inc_nxt = count_sel(dir_mask, events.starved); // R8
            end
            LPS_EV_DATA_RESPONSE_FLITS_OUT: begin
                inc_nxt = one(events.data_response_flit_out); // R10
            end
            LPS_EV_NONCOHERENT_STANDARD_FLITS_OUT: begin
                inc_nxt = one(events.noncoherent_standard_flit_out); // R10
            end
            LPS_EV_NONCOHERENT_BYPASS_FLITS_OUT: begin
                inc_nxt = events.noncoherent_bypass_flits_out; // R10
            end
            LPS_EV_HALF_LINE_EARLY_SEND: begin
                inc_nxt = one(events.half_line_send); // R11
            end
            LPS_EV_REQUEST_RING_CREDIT_MISS: begin
                inc_nxt = one(events.request_ring_credit_miss); // R12
            end
            LPS_EV_ACKNOWLEDGE_RING_CREDIT_MISS: begin
                inc_nxt = one(events.acknowledge_ring_credit_miss); // R13
            end
            LPS_EV_DATA_RING_CREDIT_MISS: begin
                inc_nxt = one(events.data_ring_credit_miss); // R14
            end
            LPS_EV_PROBE_QUEUE_CREDIT_MISS: begin
                inc_nxt = one(events.probe_queue_credit_miss); // R16
            end
            LPS_EV_SHARED_POOL_EXHAUSTED: begin
                // both sides selected adds both sides that ran dry
                inc_nxt = LPS_INC_W'(one(sel_r.mask[0] & events.pool_exhausted[0])
                    + one(sel_r.mask[1] & events.pool_exhausted[1])); // R17
            end
            LPS_EV_DATA_PACKETS_IN_FROM_HOME: begin
                inc_nxt = one(events.data_packet_in_home); // R18
            end
            LPS_EV_DATA_PACKETS_IN_FROM_ROUTER: begin
                inc_nxt = events.data_packets_in_router; // R19
            end
            default: begin
                // class credit misses occupy a contiguous code range
                if (sel_r.code >= LPS_EV_CLASS_CREDIT_MISS_FIRST && sel_r.code <= LPS_EV_CLASS_CREDIT_MISS_LAST) begin
                    inc_nxt = one(events.class_credit_miss[sel_r.code[2:0]]); // R15
                end else begin
                    known_nxt = 1'b0;
                end
            end
        endcase
        if (!sel_r.enable) begin
            inc_nxt = '0;
        end
    end

    // ------------------------------------------------------------------
    // increment output and status
    // ------------------------------------------------------------------
    logic seen_r;

    // registered so the counter sees a clean value once per clock; costs one
    // cycle of latency between an event and its count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inc_out <= LPS_INC_RESET;
        end else begin
            inc_out <= inc_nxt; // R20
        end
    end

    // sticky activity flag; a new event wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_r <= 1'b0;
        end else if (inc_nxt != '0) begin
            seen_r <= 1'b1;
        end else if (seen_clear) begin
            seen_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // bus data phase
    // ------------------------------------------------------------------
    logic [31:0] rdata_nxt;

    // read data built from the next control value so a write just before
    // a read is already visible; unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (access_ok && !hwrite) begin
            if (haddr[7:0] == LPS_ADDR_CTRL && haddr[31:8] == 24'h00_0000) begin
                rdata_nxt[LPS_CTRL_CODE_LSB +: 8] = sel_nxt.code;
                rdata_nxt[LPS_CTRL_MASK_LSB +: 8] = sel_nxt.mask;
                rdata_nxt[LPS_CTRL_EN_BIT] = sel_nxt.enable;
            end else if (haddr[7:0] == LPS_ADDR_STATUS && haddr[31:8] == 24'h00_0000) begin
                rdata_nxt[LPS_STAT_INC_LSB +: LPS_INC_W] = inc_nxt;
                rdata_nxt[LPS_STAT_KNOWN_BIT] = known_nxt;
                rdata_nxt[LPS_STAT_SEEN_BIT] = seen_r | (inc_nxt != '0);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (access_ok && !hwrite) begin
            hrdata <= rdata_nxt;
        end
    end

    // zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= LPS_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= LPS_HRESP_OKAY;
        end
    end

endmodule // lps_event_select

`default_nettype wire

// File: shared/lps_pkg.sv
/*
 * lps_pkg: constants and carrier types for the link-unit performance event
 * selector: event codes, subevent mask layout, register map and reset values.
 * Assumes a single uncore clock shared by the event sources and the bus.
 */
package lps_pkg;

    // ------------------------------------------------------------------
    // event codes
    // ------------------------------------------------------------------
    localparam logic [7:0] LPS_EV_HALF_LINE_EARLY_SEND = 8'h30;
    localparam logic [7:0] LPS_EV_EGRESS_BYPASS = 8'h40;
    localparam logic [7:0] LPS_EV_EGRESS_ARBITRATION_WINS = 8'h41;
    localparam logic [7:0] LPS_EV_EGRESS_ARBITRATION_LOSSES = 8'h42;
    localparam logic [7:0] LPS_EV_EGRESS_STARVATION_CYCLES = 8'h43;
    localparam logic [7:0] LPS_EV_HOME_TO_LINK_DATA_BYPASS = 8'h53;
    localparam logic [7:0] LPS_EV_HOME_REQUEST_BYPASS = 8'h54;
    localparam logic [7:0] LPS_EV_DATA_RESPONSE_FLITS_OUT = 8'h65;
    localparam logic [7:0] LPS_EV_NONCOHERENT_STANDARD_FLITS_OUT = 8'h67;
    localparam logic [7:0] LPS_EV_NONCOHERENT_BYPASS_FLITS_OUT = 8'h69;
    localparam logic [7:0] LPS_EV_HOME_CREDIT_RETURN_FLITS = 8'h6B;
    localparam logic [7:0] LPS_EV_DATA_PACKETS_IN_FROM_ROUTER = 8'h72;
    localparam logic [7:0] LPS_EV_DATA_PACKETS_IN_FROM_HOME = 8'h73;
    localparam logic [7:0] LPS_EV_HOME_CREDIT_CARRIER_FLITS = 8'h77;
    localparam logic [7:0] LPS_EV_CLASS_CREDIT_MISS_FIRST = 8'h80;
    localparam logic [7:0] LPS_EV_CLASS_CREDIT_MISS_LAST = 8'h85;
    localparam logic [7:0] LPS_EV_SHARED_POOL_EXHAUSTED = 8'h86;
    localparam logic [7:0] LPS_EV_REQUEST_RING_CREDIT_MISS = 8'h87;
    localparam logic [7:0] LPS_EV_ACKNOWLEDGE_RING_CREDIT_MISS = 8'h88;
    localparam logic [7:0] LPS_EV_DATA_RING_CREDIT_MISS = 8'h89;
    localparam logic [7:0] LPS_EV_PROBE_QUEUE_CREDIT_MISS = 8'h8A;

    // ------------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------------
    localparam int LPS_INC_W = 4;          // largest increment is 12
    localparam int LPS_DIRS = 6;           // 3 rings x 2 directions
    localparam int LPS_CLASSES = 6;        // system-bound classes 0x80..0x85
    localparam int LPS_CTRL_CODE_LSB = 0;
    localparam int LPS_CTRL_MASK_LSB = 8;
    localparam int LPS_CTRL_EN_BIT = 16;
    localparam int LPS_STAT_INC_LSB = 0;
    localparam int LPS_STAT_KNOWN_BIT = 8;
    localparam int LPS_STAT_SEEN_BIT = 9;

    // ------------------------------------------------------------------
    // register map (byte addresses) and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] LPS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] LPS_ADDR_STATUS = 8'h04;
    localparam logic [31:0] LPS_CTRL_RESET = 32'h0000_0000;
    localparam logic [LPS_INC_W-1:0] LPS_INC_RESET = 4'h0;

    // ahb encodings
    localparam logic [1:0] LPS_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] LPS_HTRANS_SEQ = 2'h3;
    localparam logic LPS_HRESP_OKAY = 1'b0;

    // ------------------------------------------------------------------
    // per-cycle event inputs from the unit's datapath
    // ------------------------------------------------------------------
    typedef struct packed {
        logic home_data_bypass;                    // data response bypass cycle
        logic home_credit_carrier;                 // credit idle flit in
        logic home_credit_return;                  // credit return flit out
        logic home_request_bypass;                 // coherence request bypass
        logic half_line_send;                      // half line sent early
        logic [LPS_DIRS-1:0] bypass_even;
        logic [LPS_DIRS-1:0] bypass_odd;
        logic [LPS_DIRS-1:0] win_even;
        logic [LPS_DIRS-1:0] win_odd;
        logic [LPS_DIRS-1:0] loss;
        logic [LPS_DIRS-1:0] starved;
        logic data_response_flit_out;
        logic noncoherent_standard_flit_out;
        logic [LPS_INC_W-1:0] noncoherent_bypass_flits_out;  // 0..11
        logic [LPS_CLASSES-1:0] class_credit_miss;  // bit i = code 0x80+i
        logic [1:0] pool_exhausted;                // bit0 router, bit1 home
        logic request_ring_credit_miss;
        logic acknowledge_ring_credit_miss;
        logic data_ring_credit_miss;
        logic probe_queue_credit_miss;
        logic data_packet_in_home;
        logic [LPS_INC_W-1:0] data_packets_in_router;  // 0..9
    } lps_events_t;

    // programmed selection
    typedef struct packed {
        logic enable;
        logic [7:0] mask;
        logic [7:0] code;
    } lps_select_t;

endpackage

// File: bench/lps_event_select_sva.sv
/*
 * lps_event_select_sva: port-level checks of the event selector.
 * Assumes single-word AHB-Lite writes; the control word is shadowed here.
 */
`timescale 1ns/1ns
`default_nettype none

module lps_event_select_sva
    import lps_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // events and counter side
    input wire lps_events_t events,
    input wire logic [LPS_INC_W-1:0] inc_out
);
    // ------------------------------------------------------------------
    // shadow of the control word
    // ------------------------------------------------------------------
    logic wr_ctrl_r;
    logic [31:0] ctrl_r;
    logic [16:0] sel_r;
    lps_events_t ev_r;
    wire logic on = sel_r[16];
    wire logic [7:0] code = sel_r[7:0];
    wire logic [7:0] msk = sel_r[15:8];

    // a control write is stored at the end of its data phase, as the slave does
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ctrl_r <= 1'h0;
            ctrl_r <= LPS_CTRL_RESET;
        end else if (hready) begin
            wr_ctrl_r <= hsel && htrans[1] && hwrite && haddr == 32'h0;
            if (wr_ctrl_r) begin
                ctrl_r <= hwdata;
            end
        end
    end

    // selection and events behind the value now standing on inc_out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_r <= '0;
            ev_r <= '0;
        end else begin
            sel_r <= ctrl_r[16:0];
            ev_r <= events;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_data_bypass: assert property (
        on && code == 8'h53 |-> inc_out == {3'h0, ev_r.home_data_bypass}) else $error("data bypass count");
    chk_home_credits: assert property (
        on && (code == 8'h77 || code == 8'h6B) |->
        inc_out == {3'h0, code[4] ? ev_r.home_credit_carrier : ev_r.home_credit_return}) else $error("credit flits");
    chk_request_bypass: assert property (
        on && code == 8'h54 |-> inc_out == {3'h0, ev_r.home_request_bypass}) else $error("request bypass");
    chk_loss_mask: assert property (
        on && code == 8'h42 |-> inc_out == 4'($countones(ev_r.loss & msk[5:0]))) else $error("loss count");
    chk_win_sum: assert property (
        on && code == 8'h41 |-> inc_out == 4'($countones(ev_r.win_even & msk[5:0])
        + $countones(ev_r.win_odd & msk[5:0]))) else $error("win count");
    chk_bypass_sum: assert property (
        on && code == 8'h40 |-> inc_out == 4'($countones(ev_r.bypass_even & msk[5:0])
        + $countones(ev_r.bypass_odd & msk[5:0]))) else $error("egress bypass count");
    chk_starved_mask: assert property (
        on && code == 8'h43 |-> inc_out == 4'($countones(ev_r.starved & msk[5:0]))) else $error("starved count");
    chk_bypass_flits: assert property (
        on && code == 8'h69 |-> inc_out == ev_r.noncoherent_bypass_flits_out) else $error("flit count");
    chk_class_miss: assert property (
        on && code >= 8'h80 && code <= 8'h85 |->
        inc_out == {3'h0, ev_r.class_credit_miss[code[2:0]]}) else $error("class credit miss");
    chk_pool_sides: assert property (
        on && code == 8'h86 |-> inc_out == {3'h0, msk[0] & ev_r.pool_exhausted[0]}
        + {3'h0, msk[1] & ev_r.pool_exhausted[1]}) else $error("pool exhaustion");
    chk_router_packets: assert property (
        on && code == 8'h72 |-> inc_out == ev_r.data_packets_in_router) else $error("router packets");
    chk_off_zero: assert property (
        !on || code == 8'h00 |-> inc_out == 4'h0) else $error("nonzero while idle");
    chk_bus_okay: assert property (hreadyout && hresp == LPS_HRESP_OKAY) else $error("bus answer");
endmodule // lps_event_select_sva

bind lps_event_select lps_event_select_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .events(events), .inc_out(inc_out));

`default_nettype wire

// File: bench/lps_count_model.sv
/*
 * lps_count_model: the counter beside the selector, summing its increment.
 * Assumes the selector's clock and reset.
 */
`timescale 1ns/1ns
`default_nettype none

module lps_count_model
    import lps_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // selector side
    input wire logic [LPS_INC_W-1:0] inc,
    output logic [47:0] total
);
    // each cycle's value is added once, so a held value adds every cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            total <= 48'h0;
        end else begin
            total <= total + 48'(inc);
        end
    end
endmodule // lps_count_model

`default_nettype wire

// File: bench/lps_event_select_tb.sv
/*
 * lps_event_select_tb: table of event selections, then register, burst and
 * reset cases. Assumes hready is looped back from hreadyout.
 */
`timescale 1ns/1ns
`default_nettype none

module lps_event_select_tb
    import lps_pkg::*;
;
    // row: code, mask, flags (bit0 enable, bit1 second event pattern), increment
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] msk;
        logic [1:0] fl;
        logic [3:0] exp;
    } lps_row_t;
    localparam int NROWS = 35;
    lps_row_t rows [NROWS] = '{
        '{8'h53, 8'h00, 2'h1, 4'h1}, '{8'h77, 8'h00, 2'h1, 4'h1}, '{8'h6B, 8'h00, 2'h1, 4'h1},
        '{8'h54, 8'h00, 2'h1, 4'h1}, '{8'h30, 8'h00, 2'h1, 4'h1}, '{8'h42, 8'h00, 2'h1, 4'h0},
        '{8'h42, 8'h05, 2'h1, 4'h2}, '{8'h42, 8'h3F, 2'h1, 4'h4}, '{8'h41, 8'h3F, 2'h1, 4'h6},
        '{8'h41, 8'h03, 2'h1, 4'h2}, '{8'h40, 8'h3F, 2'h1, 4'h4}, '{8'h40, 8'h0C, 2'h1, 4'h1},
        '{8'h43, 8'h30, 2'h1, 4'h1}, '{8'h65, 8'h00, 2'h1, 4'h1}, '{8'h67, 8'h00, 2'h1, 4'h1},
        '{8'h69, 8'h00, 2'h1, 4'hB}, '{8'h87, 8'h00, 2'h1, 4'h1}, '{8'h88, 8'h00, 2'h1, 4'h1},
        '{8'h89, 8'h00, 2'h1, 4'h1}, '{8'h8A, 8'h00, 2'h1, 4'h1}, '{8'h80, 8'h00, 2'h1, 4'h1},
        '{8'h85, 8'h00, 2'h1, 4'h1}, '{8'h86, 8'h01, 2'h1, 4'h1}, '{8'h86, 8'h03, 2'h1, 4'h2},
        '{8'h73, 8'h00, 2'h1, 4'h1}, '{8'h72, 8'h00, 2'h1, 4'h9}, '{8'h00, 8'h3F, 2'h1, 4'h0},
        '{8'h53, 8'h00, 2'h0, 4'h0}, '{8'h80, 8'h00, 2'h3, 4'h0}, '{8'h82, 8'h00, 2'h3, 4'h1},
        '{8'h86, 8'h01, 2'h3, 4'h0}, '{8'h86, 8'h03, 2'h3, 4'h1}, '{8'h86, 8'h02, 2'h3, 4'h1},
        '{8'h53, 8'h00, 2'h3, 4'h0}, '{8'h72, 8'h00, 2'h3, 4'h0}};
    logic hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp;
    wire logic hready = hreadyout;
    logic [31:0] hrdata;
    lps_events_t events, ev_a, ev_b, ev;
    logic [LPS_INC_W-1:0] inc_out;
    logic [47:0] total, base;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    lps_event_select dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .events(events), .inc_out(inc_out));
    lps_count_model u_cnt (.hclk(hclk), .hresetn(hresetn), .inc(inc_out), .total(total));

    // ------------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------------
    initial begin
        hclk = 1'h0;
        forever #4 hclk = ~hclk;
    end

    // a hang anywhere counts as a mismatch
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // one single transfer; entered just after a rising edge, returns at the data phase's last edge
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        hsel <= 1'h1;
        haddr <= addr;
        htrans <= LPS_HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= wdata;
        do @(posedge hclk); while (hready !== 1'h1);
        rdata = hrdata;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        events = '0;
        // pattern a: every flag set, even/odd never together in one direction
        ev_a = '1;
        ev_a.bypass_even = 6'h09;
        ev_a.bypass_odd = 6'h12;
        ev_a.win_even = 6'h15;
        ev_a.win_odd = 6'h2A;
        ev_a.loss = 6'h35;
        ev_a.starved = 6'h1E;
        ev_a.noncoherent_bypass_flits_out = 4'hB;
        ev_a.data_packets_in_router = 4'h9;
        ev_b = '0;
        ev_b.class_credit_miss = 6'h04;
        ev_b.pool_exhausted = 2'h2;
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        for (int i = 0; i < NROWS; i++) begin
            ahb(1'h1, 32'h0, {15'h0, rows[i].fl[0], rows[i].msk, rows[i].code}, rd);
            @(posedge hclk);
            events <= rows[i].fl[1] ? ev_b : ev_a;
            @(posedge hclk);
            events <= '0;
            #1;
            chk(32'(inc_out), 32'(rows[i].exp), $sformatf("row %0d", i));
        end
        // register access: readback after the write completes, unmapped place, status
        ahb(1'h1, 32'h0, 32'h0001_3F41, rd);
        ahb(1'h0, 32'h0, 32'h0, rd);
        chk(rd, 32'h0001_3F41, "ctrl readback");
        ahb(1'h1, 32'h8, 32'hFFFF_FFFF, rd);
        ahb(1'h0, 32'h8, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        ahb(1'h0, 32'h4, 32'h0, rd);
        chk(32'(rd[9:8]), 32'h3, "status flags");
        ahb(1'h1, 32'h4, 32'h200, rd);
        ahb(1'h0, 32'h4, 32'h0, rd);
        chk(32'(rd[9:8]), 32'h1, "seen cleared");
        ahb(1'h0, 32'h0, 32'h0, rd);
        chk(rd, 32'h0001_3F41, "ctrl kept");
        // bursts: a held event adds once every cycle
        for (int j = 0; j < 2; j++) begin
            ahb(1'h1, 32'h0, j ? 32'h0001_0073 : 32'h0001_0072, rd);
            @(posedge hclk);
            base = total;
            ev = '0;
            ev.data_packets_in_router = 4'h9;
            ev.data_packet_in_home = 1'h1;
            events <= ev;
            repeat (5) @(posedge hclk);
            events <= '0;
            repeat (3) @(posedge hclk);
            chk(32'(total - base), j ? 32'h5 : 32'h2D, "burst total");
        end
        // reset in mid-run with events active
        @(posedge hclk);
        hresetn <= 1'h0;
        events <= ev_a;
        @(posedge hclk);
        #1;
        chk(32'(inc_out), 32'h0, "inc in reset");
        chk(32'(hreadyout), 32'h1, "ready in reset");
        @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        ahb(1'h0, 32'h0, 32'h0, rd);
        events <= '0;
        chk(rd, LPS_CTRL_RESET, "ctrl reset value");
        #1;
        chk(32'(inc_out), 32'h0, "disabled after reset");
        end_sim();
    end
endmodule // lps_event_select_tb

`default_nettype wire
